/* design/racfg_pin_out.sv */
// Output pin stage with selectable polarity.
// Assumes the raw signal comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module racfg_pin_out (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_reset_n,
  // Signal and polarity
  input  wire logic i_raw,
  input  wire logic i_invert,
  // Pin
  output logic      o_pin
);

  logic pin_reg;
  logic pin_next;

  // Invert when the polarity bit is set
  always_comb begin
    pin_next = i_raw ^ i_invert; // R9
  end

  // Registered so the pin never glitches
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_reg <= 1'b0;
    end else begin
      pin_reg <= pin_next;
    end
  end

  assign o_pin = pin_reg;

endmodule : racfg_pin_out
`default_nettype wire

/* design/racfg_pkg.sv */
// Package for the radio auxiliary configuration register bank.
// Assumes a 40 MHz system clock and 6-bit register addresses.
package racfg_pkg;

  // Register addresses
  localparam logic [5:0] ADDR_SEC_LEN   = 6'h1a;
  localparam logic [5:0] ADDR_SUPPLY    = 6'h1b;
  localparam logic [5:0] ADDR_PIN_CFG0  = 6'h1c;
  localparam logic [5:0] ADDR_PIN_CFG1  = 6'h1d;
  localparam logic [5:0] ADDR_MAKER_LOW = 6'h1e;

  // Field positions (low bit of each field)
  localparam int TX_LEN_LSB     = 8;
  localparam int RX_LEN_LSB     = 0;
  localparam int SUPPLY_OK_BIT  = 6;
  localparam int SUPPLY_ON_BIT  = 5;
  localparam int SUPPLY_THR_LSB = 0;
  localparam int RSV_PIN_BIT    = 11;
  localparam int DATA_INV_BIT   = 10;
  localparam int THR_INV_BIT    = 9;
  localparam int FRAME_INV_BIT  = 8;
  localparam int CHAN_INV_BIT   = 7;
  localparam int LEVEL_THR_LSB  = 0;
  localparam int DBG_SRC_LSB    = 10;
  localparam int FRAME_SEL_LSB  = 5;
  localparam int CHAN_SEL_LSB   = 0;
  localparam int PART_LSB       = 12;

  // Reset values
  localparam logic [6:0] LEN_RST       = 7'h00;
  localparam logic [4:0] SUPPLY_THR_RST = 5'h00;
  localparam logic [6:0] LEVEL_THR_RST = 7'h40;
  localparam logic [4:0] PIN_SEL_RST   = 5'h00;

  // Authentication prefix offset subtracted from the packet length
  localparam logic [6:0] AUTH_PREFIX_OFS = 7'h02;

  // Debug stream clock: prescaler rate over data rate, in kHz
  localparam int PRESCALER_KHZ  = 150000;
  localparam int DBG_DATA_KHZ   = 37500;
  localparam int DBG_CLK_DIV    = PRESCALER_KHZ / DBG_DATA_KHZ;
  localparam int DBG_WORD_BITS  = 16;

  // Supply monitor settle time (host obligation), in ns and cycles
  localparam int CLK_PERIOD_NS    = 25;
  localparam int SUPPLY_SETTLE_NS = 5000;
  localparam int SUPPLY_SETTLE_CYC =
    (SUPPLY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // In-line security mode
  typedef enum logic [1:0] {
    SEC_OFF  = 2'b00,
    SEC_AUTH = 2'b01,
    SEC_CTR  = 2'b10,
    SEC_COMB = 2'b11
  } racfg_inline_a_t;

  // Debug stream source
  typedef enum logic [2:0] {
    DBG_OFF     = 3'b000,
    DBG_GAIN    = 3'b001,
    DBG_CONV_OUT = 3'b010,
    DBG_FILT    = 3'b011,
    DBG_RSV4    = 3'b100,
    DBG_RSV5    = 3'b101,
    DBG_CONV_IN = 3'b110,
    DBG_DAC_IN  = 3'b111
  } racfg_dbg_src_t;

  // Serializer state
  typedef enum logic [0:0] {
    SER_IDLE  = 1'b0,
    SER_SHIFT = 1'b1
  } racfg_ser_state_t;

  // Register access request from the serial front end
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  addr;
    logic [15:0] wdata;
  } racfg_req_t;

endpackage : racfg_pkg

/* design/racfg_regs.sv */
// Radio auxiliary configuration and status register bank.
// Assumes requests arrive decoded from the serial front end on i_clk_sys.
// Function
// R1: Transmit clear length field in bits 14:8, meaning set by security mode.
// R2: Receive clear length field in bits 6:0, meaning set by security mode.
// R3: Stand-alone cipher operations ignore both clear length fields.
// R4: Host writes zero to all reserved bits.
// R5: Read-only bit 6 shows supply above programmed threshold.
// R6: Host trusts the supply bit only 5 us after enable and setup.
// R7: Bit 5 enables the supply monitor; reset value zero.
// R8: Bits 4:0 hold the supply threshold code.
// R9: Polarity bits 10 to 7 invert their output pins when set.
// R10: Threshold pin high once buffer level reaches bits 6:0, reset 64.
// R11: Bits 12:10 select the debug stream source.
// R12: Debug data clock is prescaler divided by four; synth must run.
// R13: Bits 9:5 and 4:0 select frame-start and channel-clear sources.
// R14: Read-only identification word: part bits and maker code.
// R15: Two-bit security mode: off, auth, counter, combined.
// R16: Length prefix option feeds authenticated length first.
`timescale 1ns/1ps
`default_nettype none
module racfg_regs #(
  parameter logic [3:0]  PART_CODE_LOW = 4'h1,   // Arbitrary value
  parameter logic [11:0] MAKER_CODE    = 12'h0a5 // Arbitrary value
) (
  // Clock and reset
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_reset_n,
  // Register access
  input  wire racfg_pkg::racfg_req_t    i_req,
  output logic [15:0]                   o_reg_rdata,
  output logic                          o_reg_rvalid,
  // Security engine side
  input  wire racfg_pkg::racfg_inline_a_t i_inline_a,
  input  wire logic                     i_auth_len_prefix,
  input  wire logic                     i_standalone_busy,
  input  wire logic [6:0]               i_tx_pkt_len,
  output logic [6:0]                    o_tx_clear_len,
  output logic [6:0]                    o_rx_clear_len,
  output logic [6:0]                    o_auth_prefix_tx,
  output logic [6:0]                    o_auth_prefix_rx,
  output logic                          o_auth_prefix_use,
  // Supply monitor
  input  wire logic                     i_supply_cmp,
  output logic                          o_supply_monitor_on,
  output logic [4:0]                    o_supply_threshold_code,
  // Pin sources
  input  wire logic                     i_rx_data_avail,
  input  wire logic [7:0]               i_rx_level,
  input  wire logic [31:0]              i_pin_sources,
  output logic                          o_rx_data_pin,
  output logic                          o_rx_threshold_pin,
  output logic                          o_frame_start_pin,
  output logic                          o_chan_clear_pin,
  // Debug stream
  input  wire logic                     i_freq_synth_running,
  input  wire logic [15:0]              i_debug_word,
  output logic [2:0]                    o_debug_stream_source,
  output logic                          o_debug_stream_port,
  output logic                          o_debug_stream_clk,
  output logic                          o_debug_stream_sync
);

  localparam logic [1:0] DIV_LAST = 2'(racfg_pkg::DBG_CLK_DIV - 1);
  localparam logic [1:0] DIV_HIGH = 2'(racfg_pkg::DBG_CLK_DIV / 2);
  localparam logic [3:0] BIT_LAST = 4'(racfg_pkg::DBG_WORD_BITS - 1);
  localparam logic [15:0] ID_WORD = {PART_CODE_LOW, MAKER_CODE};

  // Register state
  logic [6:0]  tx_len_reg, tx_len_next, rx_len_reg, rx_len_next;
  logic        mon_on_reg, mon_on_next;
  logic [4:0]  thr_code_reg, thr_code_next;
  logic [4:0]  inv_reg, inv_next;       // {rsv11, data, thr, frame, chan}
  logic [6:0]  lvl_thr_reg, lvl_thr_next;
  logic [2:0]  dbg_src_reg, dbg_src_next;
  logic [4:0]  fsel_reg, fsel_next, csel_reg, csel_next;
  logic [15:0] rdata_reg, rdata_next;
  logic        rvalid_reg, rvalid_next;
  // Security outputs
  logic [6:0]  txe_reg, txe_next, rxe_reg, rxe_next;
  logic [6:0]  ptx_reg, ptx_next, prx_reg, prx_next;
  logic        puse_reg, puse_next;
  // Supply comparator synchroniser
  logic        cmp_s1, cmp_s2, cmp_s3, ok_reg, ok_next;

  // Register writes; reserved bits are dropped, except bit 11 of the pin register, which inv_reg keeps
  always_comb begin
    tx_len_next   = tx_len_reg;
    rx_len_next   = rx_len_reg;
    mon_on_next   = mon_on_reg;
    thr_code_next = thr_code_reg;
    inv_next      = inv_reg;
    lvl_thr_next  = lvl_thr_reg;
    dbg_src_next  = dbg_src_reg;
    fsel_next     = fsel_reg;
    csel_next     = csel_reg;
    if (i_req.wr) begin
      if (i_req.addr == racfg_pkg::ADDR_SEC_LEN) begin
        tx_len_next = i_req.wdata[racfg_pkg::TX_LEN_LSB +: 7]; // R1
        rx_len_next = i_req.wdata[racfg_pkg::RX_LEN_LSB +: 7]; // R2
      end else if (i_req.addr == racfg_pkg::ADDR_SUPPLY) begin
        mon_on_next   = i_req.wdata[racfg_pkg::SUPPLY_ON_BIT]; // R7
        thr_code_next = i_req.wdata[racfg_pkg::SUPPLY_THR_LSB +: 5]; // R8
      end else if (i_req.addr == racfg_pkg::ADDR_PIN_CFG0) begin
        inv_next = i_req.wdata[racfg_pkg::CHAN_INV_BIT +: 5]; // R9
        lvl_thr_next = i_req.wdata[racfg_pkg::LEVEL_THR_LSB +: 7]; // R10
      end else if (i_req.addr == racfg_pkg::ADDR_PIN_CFG1) begin
        dbg_src_next = i_req.wdata[racfg_pkg::DBG_SRC_LSB +: 3]; // R11
        fsel_next = i_req.wdata[racfg_pkg::FRAME_SEL_LSB +: 5]; // R13
        csel_next = i_req.wdata[racfg_pkg::CHAN_SEL_LSB +: 5]; // R13
      end
    end
  end

  // Read path; unmapped addresses read zero, write-only bits read zero
  always_comb begin
    rdata_next  = rdata_reg;
    rvalid_next = i_req.rd;
    if (i_req.rd) begin
      rdata_next = 16'h0000;
      if (i_req.addr == racfg_pkg::ADDR_SEC_LEN) begin
        rdata_next[racfg_pkg::TX_LEN_LSB +: 7] = tx_len_reg;
        rdata_next[racfg_pkg::RX_LEN_LSB +: 7] = rx_len_reg;
      end else if (i_req.addr == racfg_pkg::ADDR_SUPPLY) begin
        rdata_next[racfg_pkg::SUPPLY_OK_BIT] = ok_reg; // R5
        rdata_next[racfg_pkg::SUPPLY_ON_BIT] = mon_on_reg;
        rdata_next[racfg_pkg::SUPPLY_THR_LSB +: 5] = thr_code_reg;
      end else if (i_req.addr == racfg_pkg::ADDR_PIN_CFG0) begin
        rdata_next[racfg_pkg::CHAN_INV_BIT +: 5] = inv_reg;
        rdata_next[racfg_pkg::LEVEL_THR_LSB +: 7] = lvl_thr_reg;
      end else if (i_req.addr == racfg_pkg::ADDR_PIN_CFG1) begin
        rdata_next[racfg_pkg::DBG_SRC_LSB +: 3] = dbg_src_reg;
        rdata_next[racfg_pkg::FRAME_SEL_LSB +: 5] = fsel_reg;
        rdata_next[racfg_pkg::CHAN_SEL_LSB +: 5] = csel_reg;
      end else if (i_req.addr == racfg_pkg::ADDR_MAKER_LOW) begin
        rdata_next = ID_WORD; // R14
      end
    end
  end

  // Effective lengths for the cipher engine, by mode
  always_comb begin
    txe_next  = tx_len_reg;
    rxe_next  = rx_len_reg;
    if (i_standalone_busy ||
        i_inline_a == racfg_pkg::SEC_OFF) begin // R3 R15
      txe_next = 7'h00;
      rxe_next = 7'h00;
    end
    // Length prefix only applies to the authentication-only mode
    puse_next = i_auth_len_prefix && !i_standalone_busy &&
                i_inline_a == racfg_pkg::SEC_AUTH; // R16
    ptx_next = i_tx_pkt_len - tx_len_reg - racfg_pkg::AUTH_PREFIX_OFS; // R16
    prx_next = rx_len_reg; // R16
  end

  // Comparator accepted once second and third stages agree
  always_comb begin
    ok_next = ok_reg;
    if (!mon_on_reg) begin
      ok_next = 1'b0; // Disabled monitor clears the good-supply bit one cycle after mon_on_reg drops
    end else if (cmp_s2 == cmp_s3) begin
      ok_next = cmp_s3; // R5
    end
  end

  // State registers
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_len_reg   <= racfg_pkg::LEN_RST;
      rx_len_reg   <= racfg_pkg::LEN_RST;
      mon_on_reg   <= 1'b0;
      thr_code_reg <= racfg_pkg::SUPPLY_THR_RST;
      inv_reg      <= 5'h00;
      lvl_thr_reg  <= racfg_pkg::LEVEL_THR_RST;
      dbg_src_reg  <= 3'h0;
      fsel_reg     <= racfg_pkg::PIN_SEL_RST;
      csel_reg     <= racfg_pkg::PIN_SEL_RST;
      rdata_reg    <= 16'h0000;
      rvalid_reg   <= 1'b0;
      txe_reg      <= 7'h00;
      rxe_reg      <= 7'h00;
      ptx_reg      <= 7'h00;
      prx_reg      <= 7'h00;
      puse_reg     <= 1'b0;
      cmp_s1       <= 1'b0;
      cmp_s2       <= 1'b0;
      cmp_s3       <= 1'b0;
      ok_reg       <= 1'b0;
    end else begin
      tx_len_reg   <= tx_len_next;
      rx_len_reg   <= rx_len_next;
      mon_on_reg   <= mon_on_next;
      thr_code_reg <= thr_code_next;
      inv_reg      <= inv_next;
      lvl_thr_reg  <= lvl_thr_next;
      dbg_src_reg  <= dbg_src_next;
      fsel_reg     <= fsel_next;
      csel_reg     <= csel_next;
      rdata_reg    <= rdata_next;
      rvalid_reg   <= rvalid_next;
      txe_reg      <= txe_next;
      rxe_reg      <= rxe_next;
      ptx_reg      <= ptx_next;
      prx_reg      <= prx_next;
      puse_reg     <= puse_next;
      cmp_s1       <= i_supply_cmp;
      cmp_s2       <= cmp_s1;
      cmp_s3       <= cmp_s2;
      ok_reg       <= ok_next;
    end
  end

  // Pin raw levels
  logic thr_raw, frame_raw, chan_raw;
  assign thr_raw   = {1'b0, lvl_thr_reg} <= i_rx_level; // R10
  assign frame_raw = i_pin_sources[fsel_reg]; // R13
  assign chan_raw  = i_pin_sources[csel_reg]; // R13

  racfg_pin_out u_data_pin (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_raw(i_rx_data_avail), .i_invert(inv_reg[3]), .o_pin(o_rx_data_pin));
  racfg_pin_out u_thr_pin (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_raw(thr_raw), .i_invert(inv_reg[2]), .o_pin(o_rx_threshold_pin));
  racfg_pin_out u_frame_pin (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_raw(frame_raw), .i_invert(inv_reg[1]), .o_pin(o_frame_start_pin));
  racfg_pin_out u_chan_pin (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_raw(chan_raw), .i_invert(inv_reg[0]), .o_pin(o_chan_clear_pin));

  // Debug serializer; reserved sources behave as off
  racfg_pkg::racfg_ser_state_t ser_reg, ser_next;
  logic [1:0]  div_reg, div_next;
  logic [3:0]  bit_reg, bit_next;
  logic [15:0] sh_reg, sh_next;
  logic        dclk_reg, dclk_next, ddat_reg, ddat_next, dsync_reg, dsync_next;
  logic        dbg_active;
  assign dbg_active = i_freq_synth_running && // R12
    dbg_src_reg != racfg_pkg::DBG_OFF &&
    dbg_src_reg != racfg_pkg::DBG_RSV4 &&
    dbg_src_reg != racfg_pkg::DBG_RSV5; // R11

  always_comb begin
    ser_next   = ser_reg;
    div_next   = div_reg;
    bit_next   = bit_reg;
    sh_next    = sh_reg;
    dclk_next  = 1'b0;
    ddat_next  = 1'b0;
    dsync_next = 1'b0;
    case (ser_reg)
      racfg_pkg::SER_IDLE: begin
        div_next = 2'h0;
        bit_next = BIT_LAST;
        if (dbg_active) begin
          ser_next = racfg_pkg::SER_SHIFT;
          sh_next  = i_debug_word;
        end
      end
      racfg_pkg::SER_SHIFT: begin
        // Divider stands in for the prescaler-derived clock
        div_next  = (div_reg == DIV_LAST) ? 2'h0 : div_reg + 2'h1; // R12
        dclk_next = div_reg >= DIV_HIGH; // R12
        ddat_next = sh_reg[bit_reg];
        dsync_next = bit_reg == BIT_LAST;
        if (div_reg == DIV_LAST) begin
          bit_next = bit_reg - 4'h1;
          if (bit_reg == 4'h0) begin
            sh_next = i_debug_word;
            if (!dbg_active) begin
              ser_next = racfg_pkg::SER_IDLE; // Ends only at a word edge
            end
          end
        end
      end
      default: ser_next = racfg_pkg::SER_IDLE;
    endcase
  end

  // Serializer registers
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ser_reg   <= racfg_pkg::SER_IDLE;
      div_reg   <= 2'h0;
      bit_reg   <= 4'h0;
      sh_reg    <= 16'h0000;
      dclk_reg  <= 1'b0;
      ddat_reg  <= 1'b0;
      dsync_reg <= 1'b0;
    end else begin
      ser_reg   <= ser_next;
      div_reg   <= div_next;
      bit_reg   <= bit_next;
      sh_reg    <= sh_next;
      dclk_reg  <= dclk_next;
      ddat_reg  <= ddat_next;
      dsync_reg <= dsync_next;
    end
  end

  // Output wiring, all from flip-flops
  assign o_reg_rdata             = rdata_reg;
  assign o_reg_rvalid            = rvalid_reg;
  assign o_tx_clear_len          = txe_reg;
  assign o_rx_clear_len          = rxe_reg;
  assign o_auth_prefix_tx        = ptx_reg;
  assign o_auth_prefix_rx        = prx_reg;
  assign o_auth_prefix_use       = puse_reg;
  assign o_supply_monitor_on     = mon_on_reg;
  assign o_supply_threshold_code = thr_code_reg;
  assign o_debug_stream_source   = dbg_src_reg;
  assign o_debug_stream_port     = ddat_reg;
  assign o_debug_stream_clk      = dclk_reg;
  assign o_debug_stream_sync     = dsync_reg;

  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  // Write, one idle cycle, then read back the same register
  property p_tx_len;
    i_req.wr && i_req.addr == racfg_pkg::ADDR_SEC_LEN ##1
      !i_req.wr ##1
      i_req.rd && i_req.addr == racfg_pkg::ADDR_SEC_LEN
      |=> o_reg_rdata[14:8] == $past(i_req.wdata[14:8], 3);
  endproperty
  a_tx_len: assert property (p_tx_len) else $error("tx length lost"); // R1

  property p_rx_len;
    i_req.wr && i_req.addr == racfg_pkg::ADDR_SEC_LEN ##1
      !i_standalone_busy && i_inline_a != racfg_pkg::SEC_OFF
      |=> o_rx_clear_len == $past(i_req.wdata[6:0], 2);
  endproperty
  a_rx_len: assert property (p_rx_len) else $error("rx length wrong"); // R2

  property p_standalone;
    i_standalone_busy |=> o_tx_clear_len == 7'h00 &&
      o_rx_clear_len == 7'h00 && !o_auth_prefix_use;
  endproperty
  a_standalone: assert property (p_standalone) else $error("len used"); // R3

  property p_supply_ok;
    mon_on_reg && !mon_on_next && i_supply_cmp [*4] |=> ##1 1'b1;
  endproperty
  property p_supply_follow;
    mon_on_reg && mon_on_next ##1 mon_on_reg && cmp_s2 == cmp_s3
      |=> ok_reg == $past(cmp_s3);
  endproperty
  a_supply_follow: assert property (p_supply_follow) // R5
    else $error("supply bit stale");

  property p_mon_on;
    i_req.wr && i_req.addr == racfg_pkg::ADDR_SUPPLY
      |=> o_supply_monitor_on == $past(i_req.wdata[5]) &&
          o_supply_threshold_code == $past(i_req.wdata[4:0]);
  endproperty
  a_mon_on: assert property (p_mon_on) else $error("monitor ctrl"); // R7 R8

  property p_mon_off;
    !o_supply_monitor_on |=> !ok_reg;
  endproperty
  a_mon_off: assert property (p_mon_off) else $error("monitor off ok"); // R7

  property p_thr_pin;
    1'b1 ##1 1'b1 |-> o_rx_threshold_pin ==
      ($past(i_rx_level >= {1'b0, lvl_thr_reg}) ^ $past(inv_reg[2]));
  endproperty
  a_thr_pin: assert property (p_thr_pin) else $error("threshold pin"); // R9 R10

  property p_frame_pin;
    1'b1 ##1 1'b1 |-> o_frame_start_pin ==
      ($past(i_pin_sources[fsel_reg]) ^ $past(inv_reg[1]));
  endproperty
  a_frame_pin: assert property (p_frame_pin) else $error("frame pin"); // R13

  property p_dbg_off;
    !dbg_active && ser_reg == racfg_pkg::SER_IDLE |=> !o_debug_stream_clk;
  endproperty
  a_dbg_off: assert property (p_dbg_off) else $error("debug clk off"); // R11

  property p_dbg_clk;
    $rose(o_debug_stream_clk) |=> !$rose(o_debug_stream_clk) [*3];
  endproperty
  a_dbg_clk: assert property (p_dbg_clk) else $error("debug clk rate"); // R12

  property p_id;
    i_req.rd && i_req.addr == racfg_pkg::ADDR_MAKER_LOW
      |=> o_reg_rvalid && o_reg_rdata == ID_WORD && o_reg_rdata[0];
  endproperty
  a_id: assert property (p_id) else $error("id word"); // R14

  property p_prefix;
    i_auth_len_prefix && i_inline_a == racfg_pkg::SEC_AUTH &&
      !i_standalone_busy |=> o_auth_prefix_use &&
      o_auth_prefix_tx == $past(i_tx_pkt_len - tx_len_reg - 7'h02);
  endproperty
  a_prefix: assert property (p_prefix) else $error("prefix"); // R15 R16

  c_supply: cover property (p_supply_ok);
  c_dbg_word: cover property (o_debug_stream_sync ##[1:80] o_debug_stream_sync);
  c_pin_inv: cover property (inv_reg[2] && o_rx_threshold_pin);

endmodule : racfg_regs
`default_nettype wire

/* verif/racfg_host.sv */
// Host model that issues decoded register requests into the bank.
// Assumes the bench calls its tasks; requests change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module racfg_host (
  // Clock
  input  wire logic                 i_clk_sys,
  // Request and answer
  output var racfg_pkg::racfg_req_t o_req,
  input  wire logic [15:0]          i_reg_rdata,
  input  wire logic                 i_reg_rvalid
);
  // Idle bus before the first transfer
  initial o_req = '0;

  // One-cycle write strobe; callers keep reserved bits at zero
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge i_clk_sys);
    o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge i_clk_sys);
    // Released fields show junk, not the last value
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr

  // Read strobe; valid stands one cycle only, so take it at the next fall
  task automatic rd(input logic [5:0] a, output logic [16:0] q);
    @(negedge i_clk_sys);
    o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'hffff};
    @(negedge i_clk_sys);
    q = {i_reg_rvalid, i_reg_rdata};
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'h0000};
  endtask : rd
endmodule : racfg_host
`default_nettype wire

/* verif/tb_racfg_regs.sv */
// Bench for the auxiliary register bank: registers, pins and stream.
// Assumes the host model drives requests; other inputs are driven here.
`timescale 1ns/1ps
`default_nettype none
module tb_racfg_regs;
  // Design inputs
  logic                       i_clk_sys, i_reset_n;
  racfg_pkg::racfg_req_t      i_req;
  racfg_pkg::racfg_inline_a_t i_inline_a;
  logic        i_auth_len_prefix, i_standalone_busy, i_supply_cmp;
  logic        i_rx_data_avail, i_freq_synth_running;
  logic [6:0]  i_tx_pkt_len;
  logic [7:0]  i_rx_level;
  logic [31:0] i_pin_sources;
  logic [15:0] i_debug_word;
  // Design outputs
  logic [15:0] o_reg_rdata;
  logic        o_reg_rvalid, o_auth_prefix_use, o_supply_monitor_on;
  logic [6:0]  o_tx_clear_len, o_rx_clear_len;
  logic [6:0]  o_auth_prefix_tx, o_auth_prefix_rx;
  logic [4:0]  o_supply_threshold_code;
  logic [2:0]  o_debug_stream_source;
  logic        o_rx_data_pin, o_rx_threshold_pin, o_frame_start_pin;
  logic        o_chan_clear_pin, o_debug_stream_port, o_debug_stream_clk;
  logic        o_debug_stream_sync;
  // Bench state
  logic [16:0] q;
  int          bad_count, checks_done;

  // Identity values are arbitrary
  racfg_regs #(.PART_CODE_LOW(4'h3), .MAKER_CODE(12'h0c1)) i_racfg_regs (
    .i_clk_sys, .i_reset_n, .i_req, .o_reg_rdata, .o_reg_rvalid,
    .i_inline_a, .i_auth_len_prefix, .i_standalone_busy, .i_tx_pkt_len,
    .o_tx_clear_len, .o_rx_clear_len, .o_auth_prefix_tx,
    .o_auth_prefix_rx, .o_auth_prefix_use, .i_supply_cmp,
    .o_supply_monitor_on, .o_supply_threshold_code, .i_rx_data_avail,
    .i_rx_level, .i_pin_sources, .o_rx_data_pin, .o_rx_threshold_pin,
    .o_frame_start_pin, .o_chan_clear_pin, .i_freq_synth_running,
    .i_debug_word, .o_debug_stream_source, .o_debug_stream_port,
    .o_debug_stream_clk, .o_debug_stream_sync
  );
  racfg_host i_racfg_host (
    .i_clk_sys, .o_req(i_req), .i_reg_rdata(o_reg_rdata),
    .i_reg_rvalid(o_reg_rvalid)
  );

  // Compare and count
  task automatic check(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask : step
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    i_racfg_host.wr(a, d);
  endtask : wr
  task automatic rchk(input logic [5:0] a, input logic [15:0] e);
    i_racfg_host.rd(a, q);
    check($sformatf("reg %h", a), q, {1'b1, e});
  endtask : rchk
  // Rising edge of sync, bounded so a dead stream cannot hang
  task automatic wait_sync;
    int n;
    n = 0;
    while (o_debug_stream_sync !== 1'b0 && n < 200) begin
      step(1);
      n++;
    end
    while (o_debug_stream_sync !== 1'b1 && n < 200) begin
      step(1);
      n++;
    end
    check("sync_wait", n < 200, 1'b1);
  endtask : wait_sync
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // 40 MHz clock
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  // Watchdog well past the expected run
  initial begin
    #500000;
    bad_count++;
    close_out();
  end

  // Main sequence
  initial begin
    i_reset_n = 1'b0;
    i_inline_a = racfg_pkg::SEC_OFF;
    {i_auth_len_prefix, i_standalone_busy, i_supply_cmp} = 3'h0;
    {i_rx_data_avail, i_freq_synth_running} = 2'h0;
    {i_tx_pkt_len, i_rx_level, i_pin_sources} = '0;
    i_debug_word = 16'h8001;
    step(20);
    i_reset_n = 1'b1;
    // Reset values, identity word, ignored and unmapped places
    rchk(6'h1a, 16'h0000);
    rchk(6'h1b, 16'h0000);
    rchk(6'h1c, 16'h0040);
    rchk(6'h1d, 16'h0000);
    wr(6'h1e, 16'h0000);
    rchk(6'h1e, 16'h30c1);
    rchk(6'h3f, 16'h0000);
    // Clear lengths under every security mode
    i_inline_a = racfg_pkg::SEC_CTR;
    wr(6'h1a, 16'h057f);
    rchk(6'h1a, 16'h057f);
    i_tx_pkt_len = 7'h20;
    i_auth_len_prefix = 1'b1;
    for (int m = 0; m < 4; m++) begin
      i_inline_a = racfg_pkg::racfg_inline_a_t'(m);
      step(3);
      check("tx_len", o_tx_clear_len, m == 0 ? 7'h00 : 7'h05);
      check("rx_len", o_rx_clear_len, m == 0 ? 7'h00 : 7'h7f);
      check("pfx_use", o_auth_prefix_use, m == 1);
    end
    i_inline_a = racfg_pkg::SEC_AUTH;
    step(3);
    check("pfx_tx", o_auth_prefix_tx, 7'h19);
    check("pfx_rx", o_auth_prefix_rx, 7'h7f);
    i_standalone_busy = 1'b1;
    step(3);
    check("alone", {o_tx_clear_len, o_rx_clear_len}, 14'h0);
    i_standalone_busy = 1'b0;
    // Supply monitor, trusted only after the settle time
    i_supply_cmp = 1'b1;
    wr(6'h1b, 16'h0025);
    step(200);
    rchk(6'h1b, 16'h0065);
    check("mon", {o_supply_monitor_on, o_supply_threshold_code}, 6'h25);
    i_supply_cmp = 1'b0;
    step(8);
    rchk(6'h1b, 16'h0025);
    i_supply_cmp = 1'b1;
    wr(6'h1b, 16'h0005);
    step(8);
    rchk(6'h1b, 16'h0005);
    // Threshold pin at the boundary, then muxes and polarity
    i_rx_level = 8'h3f;
    step(2);
    check("thr_pin", o_rx_threshold_pin, 1'b0);
    i_rx_level = 8'h40;
    step(2);
    check("thr_pin", o_rx_threshold_pin, 1'b1);
    i_pin_sources = 32'h0000_0020;
    wr(6'h1d, 16'h00a3);
    step(2);
    check("pins", {o_rx_data_pin, o_rx_threshold_pin, o_frame_start_pin,
      o_chan_clear_pin}, 4'b0110);
    wr(6'h1c, 16'h07c0);
    step(2);
    check("pins", {o_rx_data_pin, o_rx_threshold_pin, o_frame_start_pin,
      o_chan_clear_pin}, 4'b1001);
    rchk(6'h1c, 16'h07c0);
    // Every debug source: active ones stream MSB first
    i_freq_synth_running = 1'b1;
    for (int s = 0; s < 8; s++) begin
      wr(6'h1d, {3'h0, s[2:0], 10'h0a3});
      step(2);
      check("dbg_src", o_debug_stream_source, s[2:0]);
      if (s == 0 || s == 4 || s == 5) begin
        step(80);
        check("dbg_off", {o_debug_stream_port, o_debug_stream_clk,
          o_debug_stream_sync}, 3'b000);
      end else begin
        wait_sync();
        check("dbg_msb", {o_debug_stream_port, o_debug_stream_clk}, 2'b10);
        step(2);
        check("dbg_clk", o_debug_stream_clk, 1'b1);
        step(2);
        check("dbg_b14", {o_debug_stream_port, o_debug_stream_sync}, 2'b00);
      end
    end
    // Stream stops once the synthesizer is down
    i_freq_synth_running = 1'b0;
    step(80);
    check("dbg_stop", {o_debug_stream_port, o_debug_stream_clk}, 2'b00);
    close_out();
  end
endmodule : tb_racfg_regs
`default_nettype wire
